// File: core/prwk_core.sv
// Reset generation and wake-event logic of the port
`timescale 1ns/10ps
`default_nettype none
`include "prwk_map.svh"
module prwk_core
  import prwk_pkg::*;
#(
  parameter int PULSE_CYC = `PRWK_PULSE_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic por_pin_n,
  input wire logic bus_reset_pin_n,
  input wire logic [2:0] eeprom_size_straps,
  input wire logic autoinit_strap,
  input wire logic wake_request_pin_n,
  input wire logic aux_detect_pin,
  input wire logic cpu_clock_running,
  output logic core_reset_n,
  output logic bus_unit_reset_n,
  output logic autoinit_start,
  output logic load_defaults,
  output logic io_access_enable,
  output logic mem_access_enable,
  output logic wake_cpu_interrupt,
  output logic power_cpu_interrupt,
  output logic pme_out,
  output logic pme_oe_n
);

  // Elaboration check: pulse counter needs at least one cycle
  if (PULSE_CYC < 1 || PULSE_CYC > 65535)
  begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] por_sync_q; // Power-on pin, first then second stage
  logic [1:0] bus_sync_q; // Bus reset pin
  logic [1:0] wake_sync_q; // Wake pin
  logic [1:0] aux_sync_q; // Aux detect pin
  logic wake_prev_q; // Last synchronised wake level
  logic por_prev_q; // Last synchronised power-on level

  // Two flops per pin; only stage one reads stage zero
  // wake pin synchronised
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      por_sync_q <= 2'b00;
      bus_sync_q <= 2'b00;
      wake_sync_q <= 2'b11;
      aux_sync_q <= 2'b00;
      wake_prev_q <= 1'b1;
      por_prev_q <= 1'b0;
    end
    else
    begin
      por_sync_q <= {por_sync_q[0], por_pin_n};
      bus_sync_q <= {bus_sync_q[0], bus_reset_pin_n};
      wake_sync_q <= {wake_sync_q[0], wake_request_pin_n};
      aux_sync_q <= {aux_sync_q[0], aux_detect_pin};
      wake_prev_q <= wake_sync_q[1];
      por_prev_q <= por_sync_q[1];
    end
  end

  logic por_ok; // Core powered and out of power-on reset
  logic d3cold; // Core power absent: power-on reset held
  logic aux_ok; // Aux supply present
  logic wake_active; // Wake pin asserted (low)
  logic wake_fall; // One-cycle high-to-low event
  logic wake_rise; // One-cycle low-to-high event
  assign por_ok = por_sync_q[1];
  assign d3cold = !por_sync_q[1];
  assign aux_ok = aux_sync_q[1];
  assign wake_active = !wake_sync_q[1];
  assign wake_fall = wake_prev_q && !wake_sync_q[1];
  assign wake_rise = !wake_prev_q && wake_sync_q[1];

  // ------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------
  logic wr_host_pm, wr_host_ctrl, wr_cpu_pm, wr_int_src, wr_int_en, wr_cmd;
  logic rd_cpu_pm;
  assign wr_host_pm = wr && addr == `PRWK_OFS_HOST_PM;
  assign wr_host_ctrl = wr && addr == `PRWK_OFS_HOST_CTRL;
  assign wr_cpu_pm = wr && addr == `PRWK_OFS_CPU_PM;
  assign wr_int_src = wr && addr == `PRWK_OFS_INT_SRC;
  assign wr_int_en = wr && addr == `PRWK_OFS_INT_EN;
  assign wr_cmd = wr && addr == `PRWK_OFS_CMD;
  assign rd_cpu_pm = rd && addr == `PRWK_OFS_CPU_PM;

  // ------------------------------------------------------------
  // Straps and power-state fields
  // ------------------------------------------------------------
  logic [2:0] size_straps_q; // EEPROM size straps
  logic autoinit_q; // Autoinit strap
  prwk_pstate_t req_state_q; // Host-requested state
  prwk_pstate_t cur_state_q; // State reported by CPU software
  logic d2_warm_on_wake_q;
  logic d3_warm_on_wake_q;
  logic [3:0] hw_wake_policy_q; // One bit per power state
  prwk_pstate_t host_req; // Requested state carried by a host write
  assign host_req = prwk_pstate_t'(wdata[`PRWK_B_REQ_LO +: 2]);

  // Straps are sampled by a clocked process at the power-on release
  // capture straps at release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      size_straps_q <= 3'h0;
      autoinit_q <= 1'b0;
    end
    else if (por_ok && !por_prev_q)
    begin
      size_straps_q <= eeprom_size_straps;
      autoinit_q <= autoinit_strap;
    end
  end

  // ------------------------------------------------------------
  // Internal bus reset and warm reset pulses
  // ------------------------------------------------------------
  logic [15:0] warm_cnt_q; // Warm pulse remaining
  logic [15:0] d3d0_cnt_q; // Internal bus reset remaining
  logic bus_rst; // Internal bus reset active
  logic bus_rst_prev_q;
  logic host_warm; // Host warm-reset request
  logic pm_warm; // Power request from D2/D3 with warm bit
  logic wake_warm; // Wake in D2/D3 with warm bit
  logic warm_ok; // Warm-on-wake enabled for current state
  logic d3_to_d0; // Host asks D0 while in D3

  assign bus_rst = !bus_sync_q[1] || d3d0_cnt_q != 16'h0000;
  assign warm_ok = (cur_state_q == PRWK_D2 && d2_warm_on_wake_q) || (cur_state_q == PRWK_D3 && d3_warm_on_wake_q);
  assign host_warm = wr_host_ctrl && wdata[`PRWK_B_WARM] && cur_state_q == PRWK_D0;
  assign pm_warm = wr_host_pm && host_req != req_state_q && warm_ok;
  assign wake_warm = wake_fall && warm_ok;
  assign d3_to_d0 = wr_host_pm && cur_state_q == PRWK_D3 && host_req == PRWK_D0;

  // Pulse counters; power-on reset cancels a pending pulse
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      warm_cnt_q <= 16'h0000;
      d3d0_cnt_q <= 16'h0000;
      bus_rst_prev_q <= 1'b0;
    end
    else if (!por_ok)
    begin
      warm_cnt_q <= 16'h0000;
      d3d0_cnt_q <= 16'h0000;
      bus_rst_prev_q <= 1'b0;
    end
    else
    begin
      bus_rst_prev_q <= bus_rst;
      if (host_warm || pm_warm || wake_warm)
        warm_cnt_q <= 16'(PULSE_CYC);
      else if (warm_cnt_q != 16'h0000)
        warm_cnt_q <= warm_cnt_q - 16'h0001;
      if (d3_to_d0)
        d3d0_cnt_q <= 16'(PULSE_CYC);
      else if (d3d0_cnt_q != 16'h0000)
        d3d0_cnt_q <= d3d0_cnt_q - 16'h0001;
    end
  end

  // Reset outputs; warm reset never reaches configuration state here
  // core reset is AND
  assign core_reset_n = por_ok && warm_cnt_q == 16'h0000;
  assign bus_unit_reset_n = por_ok && !bus_rst;

  // Loader kicks on bus reset release only, never on power-on alone
  // autoinit on bus reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      autoinit_start <= 1'b0;
      load_defaults <= 1'b0;
    end
    else
    begin
      autoinit_start <= por_ok && bus_rst_prev_q && !bus_rst && autoinit_q;
      load_defaults <= por_ok && bus_rst_prev_q && !bus_rst && !autoinit_q;
    end
  end

  // ------------------------------------------------------------
  // Configuration state: requested state and command enables
  // ------------------------------------------------------------
  logic io_en_q, mem_en_q; // Stored command enables

  // Cleared by power-on and bus reset; warm reset does not touch them
  // warm leaves config
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_state_q <= PRWK_D0;
      io_en_q <= 1'b0;
      mem_en_q <= 1'b0;
    end
    else if (!por_ok || bus_rst)
    begin
      req_state_q <= PRWK_D0;
      io_en_q <= 1'b0;
      mem_en_q <= 1'b0;
    end
    else
    begin
      if (wr_host_pm)
        req_state_q <= host_req;
      if (wr_cmd)
      begin
        io_en_q <= wdata[`PRWK_B_IOEN];
        mem_en_q <= wdata[`PRWK_B_MEMEN];
      end
    end
  end

  // Enables seen by the bus unit are masked outside D0
  // mask outside D0
  assign io_access_enable = io_en_q && req_state_q == PRWK_D0;
  assign mem_access_enable = mem_en_q && req_state_q == PRWK_D0;

  // CPU-side control fields, cleared by power-on only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_state_q <= PRWK_D0;
      d2_warm_on_wake_q <= 1'b0;
      d3_warm_on_wake_q <= 1'b0;
      hw_wake_policy_q <= 4'h0;
    end
    else if (!por_ok)
    begin
      cur_state_q <= PRWK_D0;
      d2_warm_on_wake_q <= 1'b0;
      d3_warm_on_wake_q <= 1'b0;
      hw_wake_policy_q <= 4'h0;
    end
    else if (wr_cpu_pm)
    begin
      cur_state_q <= prwk_pstate_t'(wdata[`PRWK_B_CUR_LO +: 2]);
      d2_warm_on_wake_q <= wdata[`PRWK_B_D2W];
      d3_warm_on_wake_q <= wdata[`PRWK_B_D3W];
      hw_wake_policy_q <= wdata[`PRWK_B_POL_LO +: 4];
    end
  end

  // ------------------------------------------------------------
  // Sticky wake status and enable (aux power-up reset; without aux, a bus reset also clears status)
  // ------------------------------------------------------------
  logic wake_status_q, wake_enable_q;
  logic stat_set; // Hardware or CPU set event
  logic stat_clr; // Host, CPU or aux-less bus reset clear event
  logic host_stat_clr; // Host write of 1 to status
  logic host_en_clr; // Host write of 0 to enable
  logic cpu_en_w1; // CPU write of 1 to its enable bit
  logic aux_bus_clr; // Bus reset without aux supply

  assign host_stat_clr = wr_host_pm && wdata[`PRWK_B_STAT];
  assign host_en_clr = wr_host_pm && !wdata[`PRWK_B_EN];
  assign cpu_en_w1 = wr_cpu_pm && wdata[`PRWK_B_EN];
  assign aux_bus_clr = !aux_ok && bus_rst;
  assign stat_set = (d3cold && (wake_fall || wake_rise)) || (por_ok && wr_cpu_pm && wdata[`PRWK_B_STAT]);
  assign stat_clr = host_stat_clr || cpu_en_w1 || aux_bus_clr;

  // Set wins over any clear arriving in the same cycle
  // sticky bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_status_q <= 1'b0;
    else if (stat_set)
      wake_status_q <= 1'b1;
    else if (stat_clr)
      wake_status_q <= 1'b0;
  end

  // Enable: host write 1 is the only way up
  // only host sets
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_enable_q <= 1'b0;
    else if (!aux_ok)
      wake_enable_q <= 1'b0;
    else if (wr_host_pm)
      wake_enable_q <= wdata[`PRWK_B_EN];
    else if (cpu_en_w1)
      wake_enable_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Wake output driver and driven flag
  // ------------------------------------------------------------
  logic pme_q; // Output latched active
  logic pme_set; // Wake condition worth signalling
  logic drvn_q; // Driven flag seen by CPU
  logic pme_drive; // Pin actually driven low

  assign pme_set = wake_active && (d3cold || hw_wake_policy_q[cur_state_q]);

  // Latches until a host clear; resets of the core do not release it
  // only host clears release
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pme_q <= 1'b0;
    else if (pme_set && wake_enable_q)
      pme_q <= 1'b1;
    else if (host_stat_clr || host_en_clr)
      pme_q <= 1'b0;
  end

  assign pme_drive = pme_q && wake_enable_q;
  // Open drain: float while aux supply missing
  assign pme_out = 1'b0;
  assign pme_oe_n = !(pme_drive && aux_ok);

  // Read clears, but a live condition re-sets it at once
  // read clears, re-sets
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      drvn_q <= 1'b0;
    else if (pme_drive || (wake_enable_q && wake_status_q))
      drvn_q <= 1'b1;
    else if (rd_cpu_pm)
      drvn_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Interrupt source and enable
  // ------------------------------------------------------------
  logic [2:0] int_src_q, int_en_q;
  logic [2:0] int_set;
  logic pwr_change; // Host changed the requested state
  assign pwr_change = wr_host_pm && host_req != req_state_q;
  assign int_set = {(por_ok && (pwr_change || (bus_rst && !bus_rst_prev_q))), por_ok && wake_rise, por_ok && wake_fall};

  // Write-one-to-clear; set wins; power-on clears without raising
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_src_q <= `PRWK_RST_FLAGS;
      int_en_q <= `PRWK_RST_FLAGS;
    end
    else if (!por_ok)
    begin
      int_src_q <= `PRWK_RST_FLAGS;
      int_en_q <= `PRWK_RST_FLAGS;
    end
    else
    begin
      int_src_q <= int_set | (int_src_q & ~(wr_int_src ? wdata[2:0] : 3'h0));
      if (wr_int_en)
        int_en_q <= wdata[2:0];
    end
  end

  // The power interrupt cannot reach a CPU whose clocks are stopped; the wake interrupt is not gated
  assign wake_cpu_interrupt = |(int_src_q[1:0] & int_en_q[1:0]);
  assign power_cpu_interrupt = int_src_q[`PRWK_B_PWR] && int_en_q[`PRWK_B_PWR] && cpu_clock_running;

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      `PRWK_OFS_HOST_PM:
      begin
        rd_mux[`PRWK_B_REQ_LO +: 2] = req_state_q;
        rd_mux[`PRWK_B_EN] = wake_enable_q;
        rd_mux[`PRWK_B_STAT] = wake_status_q;
      end
      `PRWK_OFS_CPU_PM:
      begin
        rd_mux[`PRWK_B_CUR_LO +: 2] = cur_state_q;
        rd_mux[`PRWK_B_D2W] = d2_warm_on_wake_q;
        rd_mux[`PRWK_B_D3W] = d3_warm_on_wake_q;
        rd_mux[`PRWK_B_POL_LO +: 4] = hw_wake_policy_q;
        rd_mux[`PRWK_B_EN] = wake_enable_q;
        rd_mux[`PRWK_B_DRVN] = drvn_q;
        rd_mux[`PRWK_B_AUX] = aux_ok;
        rd_mux[`PRWK_B_REQR_LO +: 2] = req_state_q;
        rd_mux[`PRWK_B_STAT] = wake_status_q;
        rd_mux[`PRWK_B_STRAP_LO +: 4] = {autoinit_q, size_straps_q};
      end
      `PRWK_OFS_INT_SRC: rd_mux[2:0] = int_src_q;
      `PRWK_OFS_INT_EN: rd_mux[2:0] = int_en_q;
      `PRWK_OFS_CMD: rd_mux[1:0] = {mem_en_q, io_en_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Unmapped reads and idle cycles return zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 32'h0000_0000;
    else
      rdata <= rd ? rd_mux : 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_host_warm;
    por_ok && wr_host_ctrl && wdata[`PRWK_B_WARM] && cur_state_q == PRWK_D0;
  endsequence
  sequence s_warm_low;
    !core_reset_n [*2];
  endsequence

  a_warm_from_host: assert property (s_host_warm |=> s_warm_low)
    else $error("host warm reset not issued");
  a_core_reset_and: assert property (core_reset_n == (por_ok && warm_cnt_q == 16'h0000))
    else $error("core reset not AND of resets");
  a_pme_blocked: assert property (!wake_enable_q |-> pme_oe_n)
    else $error("wake output driven while disabled");
  a_cmd_masked: assert property (req_state_q != PRWK_D0 |-> !io_access_enable && !mem_access_enable)
    else $error("enables not masked outside D0");
  a_aux_holds_en: assert property (!aux_ok |=> !wake_enable_q)
    else $error("enable set without aux");
  a_cpu_no_set: assert property (wr_cpu_pm && !wr_host_pm && !wake_enable_q |=> !wake_enable_q)
    else $error("CPU set wake enable");
  a_stat_host_clr: assert property (host_stat_clr && !stat_set |=> !wake_status_q)
    else $error("status not cleared by host");
  a_fall_flag_set: assert property (por_ok && wake_fall |=> int_src_q[`PRWK_B_FALL])
    else $error("fall flag not set");
  a_pme_holds: assert property (pme_drive && !host_stat_clr && !host_en_clr |=> pme_q)
    else $error("wake output released without host clear");
  a_bus_rst_req: assert property (por_ok && bus_rst |=> req_state_q == PRWK_D0 && !io_en_q && !mem_en_q)
    else $error("bus reset did not clear state");

endmodule
`default_nettype wire

// File: core/prwk_map.svh
// Register offsets, field positions, reset values and timing counts of the reset and wake block
`ifndef PRWK_MAP_SVH
`define PRWK_MAP_SVH
// Register byte offsets
`define PRWK_OFS_HOST_PM 8'h00
`define PRWK_OFS_HOST_CTRL 8'h04
`define PRWK_OFS_CPU_PM 8'h08
`define PRWK_OFS_INT_SRC 8'h0C
`define PRWK_OFS_INT_EN 8'h10
`define PRWK_OFS_CMD 8'h14
// Field positions
`define PRWK_B_REQ_LO 0
`define PRWK_B_EN 8
`define PRWK_B_STAT 15
`define PRWK_B_WARM 0
`define PRWK_B_CUR_LO 0
`define PRWK_B_D2W 2
`define PRWK_B_D3W 3
`define PRWK_B_POL_LO 4
`define PRWK_B_DRVN 9
`define PRWK_B_AUX 10
`define PRWK_B_REQR_LO 11
`define PRWK_B_STRAP_LO 16
`define PRWK_B_FALL 0
`define PRWK_B_RISE 1
`define PRWK_B_PWR 2
`define PRWK_B_IOEN 0
`define PRWK_B_MEMEN 1
// Reset values
`define PRWK_RST_FLAGS 3'h0
`define PRWK_RST_STATE 2'h0
// Timing: internal reset pulse length
`define PRWK_PULSE_NS 1000
`define PRWK_CLK_NS 40
`define PRWK_PULSE_CYC (`PRWK_PULSE_NS / `PRWK_CLK_NS)
`endif

// File: core/prwk_pkg.sv
// Types shared by the reset and wake block
package prwk_pkg;
  // Device power states as coded in the state fields
  typedef enum logic [1:0]
  {
    PRWK_D0 = 2'b00,
    PRWK_D1 = 2'b01,
    PRWK_D2 = 2'b10,
    PRWK_D3 = 2'b11
  } prwk_pstate_t;
endpackage

// File: verification/prwk_core_tb.sv
// Self-checking bench for the reset and wake block
`timescale 1ns/10ps
`default_nettype none
`include "prwk_map.svh"
module prwk_core_tb;
  import prwk_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic por_pin_n = 1'b0;
  logic bus_reset_pin_n = 1'b1;
  logic wake_active = 1'b0;
  logic aux_detect_pin = 1'b1;
  logic cpu_clock_running = 1'b1;
  logic autoinit_strap_v = 1'b0;
  logic [31:0] rdata;
  logic wake_pin_n, pme_line, pme_oe_n, pme_out;
  logic core_reset_n, bus_unit_reset_n, autoinit_start, load_defaults;
  logic io_en, mem_en, wake_irq, power_irq;
  int n_errors = 0;
  int num_checks = 0;
  int n_ai = 0;
  int n_ld = 0;
  int n_cyc = 0;
  logic seen;
  // --------------------------------------------------
  // Clock, DUT and far side
  // --------------------------------------------------
  always #20 clk = ~clk;
  // Short pulse keeps the warm-reset walk brief
  prwk_core #(.PULSE_CYC(2)) i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .por_pin_n(por_pin_n), .bus_reset_pin_n(bus_reset_pin_n),
    .eeprom_size_straps(3'h5), .autoinit_strap(autoinit_strap_v), .wake_request_pin_n(wake_pin_n),
    .aux_detect_pin(aux_detect_pin), .cpu_clock_running(cpu_clock_running), .core_reset_n(core_reset_n),
    .bus_unit_reset_n(bus_unit_reset_n), .autoinit_start(autoinit_start), .load_defaults(load_defaults),
    .io_access_enable(io_en), .mem_access_enable(mem_en), .wake_cpu_interrupt(wake_irq),
    .power_cpu_interrupt(power_irq), .pme_out(pme_out), .pme_oe_n(pme_oe_n));
  prwk_host_model i_host (.wake_active(wake_active), .pme_oe_n(pme_oe_n), .pme_out(pme_out),
    .wake_request_pin_n(wake_pin_n), .pme_line(pme_line));
  // Count loader pulses and cut a hang short
  always @(posedge clk)
  begin
    if (autoinit_start === 1'b1)
      n_ai++;
    if (load_defaults === 1'b1)
      n_ld++;
    n_cyc++;
    if (n_cyc == 4000)
    begin
      n_errors++;
      complete_run();
    end
  end
  // --------------------------------------------------
  // Access tasks
  // --------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata & m, exp);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // --------------------------------------------------
  // Sequence
  // --------------------------------------------------
  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    cyc(2);
    por_pin_n <= 1'b1;
    cyc(6);
    rdchk(`PRWK_OFS_CPU_PM, 32'h000F_0400, 32'h0005_0400, "straps aux");
    chk("loader after power-on", n_ai, 0);
    // Bus reset with the autoinit strap low loads defaults
    bus_reset_pin_n <= 1'b0;
    cyc(4);
    bus_reset_pin_n <= 1'b1;
    cyc(6);
    chk("defaults pulse", n_ld, 1);
    wr32(`PRWK_OFS_INT_SRC, 32'h0000_0004);
    wr32(`PRWK_OFS_INT_EN, 32'h0000_0007);
    wr32(`PRWK_OFS_CMD, 32'h0000_0003);
    wr32(`PRWK_OFS_HOST_CTRL, 32'h0000_0001);
    #1;
    chk("core reset", core_reset_n, 0);
    cyc(4);
    chk("core reset end", core_reset_n, 1);
    chk("enables kept", {mem_en, io_en}, 2'h3);
    // Requested D1 masks the enables and flags the CPU
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0001);
    cyc(1);
    chk("enables masked", {mem_en, io_en}, 2'h0);
    chk("power irq", power_irq, 1);
    // Stopped CPU clocks hold the power interrupt back
    cpu_clock_running <= 1'b0;
    cyc(1);
    chk("power irq gated", power_irq, 0);
    cpu_clock_running <= 1'b1;
    rdchk(`PRWK_OFS_INT_SRC, 32'h0000_0004, 32'h0000_0004, "power flag");
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0000);
    wr32(`PRWK_OFS_INT_SRC, 32'h0000_0004);
    cyc(1);
    chk("enables restored", {mem_en, io_en}, 2'h3);
    // Policy set but enable clear: edges flag, line stays released
    wr32(`PRWK_OFS_CPU_PM, 32'h0000_0010);
    wake_active <= 1'b1;
    cyc(6);
    chk("blocked line", pme_line, 1);
    chk("wake irq", wake_irq, 1);
    rdchk(`PRWK_OFS_INT_SRC, 32'h0000_0003, 32'h0000_0001, "fall flag");
    wr32(`PRWK_OFS_INT_SRC, 32'h0000_0003);
    wake_active <= 1'b0;
    cyc(6);
    rdchk(`PRWK_OFS_INT_SRC, 32'h0000_0003, 32'h0000_0002, "rise flag");
    wr32(`PRWK_OFS_INT_SRC, 32'h0000_0003);
    cyc(1);
    chk("wake irq clear", wake_irq, 0);
    // Enable from host, status from CPU, then a wake drives the line
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0100);
    wr32(`PRWK_OFS_CPU_PM, 32'h0000_8010);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8100, 32'h0000_8100, "status enable");
    wake_active <= 1'b1;
    cyc(6);
    wake_active <= 1'b0;
    cyc(6);
    chk("line held", pme_line, 0);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_0200, 32'h0000_0200, "driven");
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_0200, 32'h0000_0200, "driven again");
    // Resets leave sticky bits and the driven line alone; straps change
    por_pin_n <= 1'b0;
    autoinit_strap_v <= 1'b1;
    cyc(4);
    chk("line in por", pme_line, 0);
    por_pin_n <= 1'b1;
    cyc(6);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8100, 32'h0000_8100, "sticky por");
    wr32(`PRWK_OFS_CMD, 32'h0000_0003);
    bus_reset_pin_n <= 1'b0;
    cyc(4);
    chk("bus unit reset", bus_unit_reset_n, 0);
    bus_reset_pin_n <= 1'b1;
    cyc(6);
    chk("loader pulses", n_ai, 1);
    chk("no defaults pulse", n_ld, 1);
    chk("enables cleared", {mem_en, io_en}, 2'h0);
    chk("line in bus reset", pme_line, 0);
    rdchk(`PRWK_OFS_INT_SRC, 32'h0000_0004, 32'h0000_0004, "implicit state write");
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8100, 32'h0000_8100, "sticky bus reset");
    // Host clears status, keeps enable; then writes enable 0
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_8100);
    cyc(1);
    chk("line released", pme_line, 1);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8100, 32'h0000_0100, "host status clear");
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0000);
    // The read above cleared the driven flag, nothing re-sets it
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_0300, 32'h0000_0000, "host enable clear");
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0100);
    wr32(`PRWK_OFS_CPU_PM, 32'h0000_8000);
    wr32(`PRWK_OFS_CPU_PM, 32'h0000_0100);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8100, 32'h0000_0000, "cpu clear");
    // D3 with warm-on-wake: a wake edge pulses the core reset
    wr32(`PRWK_OFS_CPU_PM, 32'h0000_000B);
    wake_active <= 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (core_reset_n === 1'b0)
        seen = 1'b1;
    end
    chk("warm on wake", seen, 1);
    wake_active <= 1'b0;
    // Host asking D0 from D3 pulses the internal bus reset
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0000);
    #1;
    chk("d3 to d0 bus reset", bus_unit_reset_n, 0);
    // Without aux power the enable cannot be set
    aux_detect_pin <= 1'b0;
    cyc(4);
    wr32(`PRWK_OFS_HOST_PM, 32'h0000_0100);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_0500, 32'h0000_0000, "aux absent");
    // Core power off: a wake edge still sets status
    por_pin_n <= 1'b0;
    cyc(4);
    wake_active <= 1'b1;
    cyc(6);
    por_pin_n <= 1'b1;
    wake_active <= 1'b0;
    cyc(6);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8000, 32'h0000_8000, "cold wake status");
    // Without aux a bus reset clears status
    bus_reset_pin_n <= 1'b0;
    cyc(4);
    bus_reset_pin_n <= 1'b1;
    cyc(6);
    rdchk(`PRWK_OFS_CPU_PM, 32'h0000_8000, 32'h0000_0000, "aux bus clear");
    complete_run();
  end
endmodule
`default_nettype wire

// File: verification/prwk_host_model.sv
// Far-side pin model: wake switch and the pulled-up wake-event line
`timescale 1ns/10ps
`default_nettype none
module prwk_host_model
(
  input wire logic wake_active,
  input wire logic pme_oe_n,
  input wire logic pme_out,
  output logic wake_request_pin_n,
  output logic pme_line
);
  // Wake switch pulls its pin low while pressed
  assign wake_request_pin_n = ~wake_active;
  // Open-drain line with pull-up, so a released line reads high, never a stale level
  assign pme_line = pme_oe_n ? 1'b1 : pme_out;
endmodule
`default_nettype wire
